// File: logic/dual_feedback_setpoint_combiner.sv
// Feedback combining and setpoint selection ahead of the process regulator
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "dfc_defs.svh"
module dual_feedback_setpoint_combiner #(
  parameter int W = 16
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic signed [W-1:0] term1_value,
  input  wire logic signed [W-1:0] term2_value,
  input  wire logic signed [W-1:0] remote_ref,
  output logic signed [W+3:0]      feedback_out,
  output logic signed [W+3:0]      reference_out,
  output logic signed [W+3:0]      error_out,
  output logic                     zone2_active
);

  localparam int X = W + 4;

  typedef logic signed [X-1:0] val_t;

  typedef struct packed {
    logic                    shape_q;
    logic                    closed_q;
    dfc_pkg::combine_t       combine_q;
    logic signed [W-1:0]     bus_fb1_q;
    logic signed [W-1:0]     bus_fb2_q;
    logic signed [W-1:0]     sp1_q;
    logic signed [W-1:0]     sp2_q;
    logic signed [W-1:0]     ref_min_q;
    logic signed [W-1:0]     ref_max_q;
    val_t                    fb1_q;
    val_t                    fb2_q;
    val_t                    fb_out_q;
    val_t                    ref_out_q;
    val_t                    err_out_q;
    logic                    zone2_q;
    logic [31:0]             prdata_q;
    logic                    pready_q;
    logic                    pslverr_q;
  } state_t;

  state_t st_q;
  state_t st_d;

  // Sign extension of a bus-width value
  function automatic val_t sx(input logic signed [W-1:0] v);
    sx = val_t'(v);
  endfunction

  // Integer square root, negative inputs give zero
  function automatic val_t isqrt(input val_t v);
    logic [X-1:0] x;
    logic [X-1:0] r;
    logic [X-1:0] b;
    x = v[X-1] ? '0 : v;
    r = '0;
    b = {2'b01, {(X-2){1'b0}}};
    for (int i = 0; i < X / 2; i++)
    begin
      if (x >= r + b)
      begin
        x = x - r - b;
        r = (r >> 1) + b;
      end
      else
      begin
        r = r >> 1;
      end
      b = b >> 2;
    end
    isqrt = val_t'(r);
  endfunction

  // Limit a setpoint to the reference range
  function automatic val_t clamp(input logic signed [W-1:0] v,
                                 input logic signed [W-1:0] lo,
                                 input logic signed [W-1:0] hi);
    if (v < lo)
      clamp = sx(lo);
    else if (v > hi)
      clamp = sx(hi);
    else
      clamp = sx(v);
  endfunction

  // Write data as a signed bus-width value
  function automatic logic signed [W-1:0] wv(input logic [31:0] d);
    wv = d[W-1:0];
  endfunction

  // Read data from a signed value, sign filled to 32 bits
  function automatic logic [31:0] rv(input val_t v);
    rv = 32'(v);
  endfunction

  val_t sum1;
  val_t sum2;
  val_t sp1c;
  val_t sp2c;
  val_t err1;
  val_t err2;
  val_t two_sum;
  val_t fb_sel;
  val_t sp_sel;
  logic pick2;
  logic setup;
  logic access;

  // Datapath terms
  always_comb
  begin
    sum1 = sx(st_q.bus_fb1_q) + sx(term1_value);
    sum2 = sx(st_q.bus_fb2_q) + sx(term2_value);
    sp1c = clamp(st_q.sp1_q, st_q.ref_min_q, st_q.ref_max_q);
    sp2c = clamp(st_q.sp2_q, st_q.ref_min_q, st_q.ref_max_q);
    err1 = sp1c - st_q.fb1_q;
    err2 = sp2c - st_q.fb2_q;
    // four spare bits cover the sum
    two_sum = st_q.fb1_q + st_q.fb2_q;
    setup = psel && !penable;
    access = psel && penable && st_q.pready_q;
  end

  // Combine selection
  always_comb
  begin
    pick2 = 1'b0;
    sp_sel = sp1c;
    case (st_q.combine_q)
      dfc_pkg::CMB_MIN: fb_sel = (st_q.fb2_q < st_q.fb1_q) ? st_q.fb2_q : st_q.fb1_q;
      dfc_pkg::CMB_MAX: fb_sel = (st_q.fb2_q > st_q.fb1_q) ? st_q.fb2_q : st_q.fb1_q;
      dfc_pkg::CMB_SUM: fb_sel = two_sum;
      dfc_pkg::CMB_DIFF: fb_sel = st_q.fb2_q - st_q.fb1_q;
      dfc_pkg::CMB_AVG: fb_sel = two_sum >>> 1;
      dfc_pkg::CMB_ZMAXERR:
      begin
        pick2 = err2 > err1;
        fb_sel = pick2 ? st_q.fb2_q : st_q.fb1_q;
        sp_sel = pick2 ? sp2c : sp1c;
      end
      dfc_pkg::CMB_ZMINERR:
      begin
        pick2 = err2 < err1;
        fb_sel = pick2 ? st_q.fb2_q : st_q.fb1_q;
        sp_sel = pick2 ? sp2c : sp1c;
      end
      dfc_pkg::CMB_FB1: fb_sel = st_q.fb1_q;
      dfc_pkg::CMB_FB2:
      begin
        pick2 = 1'b1;
        fb_sel = st_q.fb2_q;
        sp_sel = sp2c;
      end
      default: fb_sel = st_q.fb1_q;
    endcase
  end

  // Next state: bus slave, configuration and pipeline
  always_comb
  begin
    st_d = st_q;
    st_d.fb1_q = st_q.shape_q ? isqrt(sum1) : sum1;
    st_d.fb2_q = st_q.shape_q ? isqrt(sum2) : sum2;
    // feedback stays live in open loop
    st_d.fb_out_q = fb_sel;
    if (st_q.closed_q)
    begin
      st_d.ref_out_q = sx(remote_ref) + sp_sel;
      st_d.zone2_q = pick2;
    end
    else
    begin
      st_d.ref_out_q = sx(remote_ref);
      st_d.zone2_q = 1'b0;
    end
    st_d.err_out_q = st_d.ref_out_q - fb_sel;
    st_d.pready_q = setup;
    if (setup)
    begin
      st_d.pslverr_q = 1'b0;
      st_d.prdata_q = '0;
      case (paddr)
        `DFC_ADDR_CTRL:
        begin
          st_d.prdata_q[`DFC_CTRL_SHAPE_BIT] = st_q.shape_q;
          st_d.prdata_q[`DFC_CTRL_CLOSED_BIT] = st_q.closed_q;
        end
        `DFC_ADDR_COMBINE: st_d.prdata_q[3:0] = st_q.combine_q;
        `DFC_ADDR_BUS_FB1: st_d.prdata_q = rv(sx(st_q.bus_fb1_q));
        `DFC_ADDR_BUS_FB2: st_d.prdata_q = rv(sx(st_q.bus_fb2_q));
        `DFC_ADDR_SP1:     st_d.prdata_q = rv(sx(st_q.sp1_q));
        `DFC_ADDR_SP2:     st_d.prdata_q = rv(sx(st_q.sp2_q));
        `DFC_ADDR_REF_MIN: st_d.prdata_q = rv(sx(st_q.ref_min_q));
        `DFC_ADDR_REF_MAX: st_d.prdata_q = rv(sx(st_q.ref_max_q));
        `DFC_ADDR_FB_OUT:  st_d.prdata_q = rv(st_q.fb_out_q);
        `DFC_ADDR_REF_OUT: st_d.prdata_q = rv(st_q.ref_out_q);
        `DFC_ADDR_ERR_OUT: st_d.prdata_q = rv(st_q.err_out_q);
        `DFC_ADDR_ZONE:    st_d.prdata_q[0] = st_q.zone2_q;
        default:           st_d.pslverr_q = 1'b1;
      endcase
      if (pwrite)
      begin
        st_d.prdata_q = '0;
      end
    end
    // Writes take effect on the completing access edge
    if (access && pwrite && !st_q.pslverr_q)
    begin
      case (paddr)
        `DFC_ADDR_CTRL:
        begin
          st_d.shape_q = pwdata[`DFC_CTRL_SHAPE_BIT];
          st_d.closed_q = pwdata[`DFC_CTRL_CLOSED_BIT];
        end
        `DFC_ADDR_COMBINE:
        begin
          if (pwdata[3:0] <= `DFC_CMB_FB2)
            st_d.combine_q = dfc_pkg::combine_t'(pwdata[3:0]);
        end
        // bus feedback written over the bus only
        `DFC_ADDR_BUS_FB1: st_d.bus_fb1_q = wv(pwdata);
        `DFC_ADDR_BUS_FB2: st_d.bus_fb2_q = wv(pwdata);
        `DFC_ADDR_SP1:     st_d.sp1_q = wv(pwdata);
        `DFC_ADDR_SP2:     st_d.sp2_q = wv(pwdata);
        `DFC_ADDR_REF_MIN: st_d.ref_min_q = wv(pwdata);
        `DFC_ADDR_REF_MAX: st_d.ref_max_q = wv(pwdata);
        default:           st_d.pslverr_q = st_q.pslverr_q;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.combine_q <= dfc_pkg::combine_t'(`DFC_RST_COMBINE);
      st_q.sp1_q <= `DFC_RST_SP;
      st_q.sp2_q <= `DFC_RST_SP;
      st_q.ref_min_q <= `DFC_RST_REF_MIN;
      st_q.ref_max_q <= `DFC_RST_REF_MAX;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign prdata        = st_q.prdata_q;
  assign pready        = st_q.pready_q;
  assign pslverr       = st_q.pslverr_q;
  assign feedback_out  = st_q.fb_out_q;
  assign reference_out = st_q.ref_out_q;
  assign error_out     = st_q.err_out_q;
  assign zone2_active  = st_q.zone2_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    ##1 pready;
  endsequence

  a_fb1_sum: assert property (!st_q.shape_q |=> st_q.fb1_q == $past(sum1))
    else $error("feedback one is not the sum");
  a_fb2_sum: assert property (!st_q.shape_q |=> st_q.fb2_q == $past(sum2))
    else $error("feedback two is not the sum");
  a_fb_root: assert property (st_q.shape_q && !sum1[X-1]
      |=> st_q.fb1_q * st_q.fb1_q <= $past(sum1))
    else $error("square root too large");
  a_min_pick: assert property (st_q.combine_q == dfc_pkg::CMB_MIN
      |=> feedback_out <= $past(st_q.fb1_q) && feedback_out <= $past(st_q.fb2_q))
    else $error("minimum not delivered");
  a_max_pick: assert property (st_q.combine_q == dfc_pkg::CMB_MAX
      |=> feedback_out >= $past(st_q.fb1_q) && feedback_out >= $past(st_q.fb2_q))
    else $error("maximum not delivered");
  a_diff_out: assert property (st_q.combine_q == dfc_pkg::CMB_DIFF
      |=> feedback_out == $past(st_q.fb2_q) - $past(st_q.fb1_q))
    else $error("difference wrong");
  a_zone_larger: assert property (st_q.closed_q && st_q.combine_q == dfc_pkg::CMB_ZMAXERR
      |=> error_out - sx($past(remote_ref)) >= $past(err1)
          && error_out - sx($past(remote_ref)) >= $past(err2))
    else $error("larger zone error not taken");
  // second setpoint in closed loop only
  a_sp2_closed: assert property (zone2_active |-> $past(st_q.closed_q))
    else $error("setpoint two used in open loop");
  a_ref_single: assert property (st_q.closed_q && st_q.combine_q == dfc_pkg::CMB_FB1
      |=> reference_out == sx($past(remote_ref)) + $past(sp1c))
    else $error("reference is not remote plus setpoint one");
  // Zero wait bus answer
  a_bus_answer: assert property (s_setup |-> s_answer)
    else $error("bus answer late");

endmodule

// File: logic/dfc_defs.svh
// Constants for the dual feedback setpoint combiner
//
// Summary of operation
// - Feedback one is bus feedback one plus the first voltage input.
// - Feedback two is bus feedback two plus the second voltage input.
// - Shaping code 0 passes feedback linearly; code 1 takes its square root.
// - Combine selector takes codes 0 to 8 for nine combine functions.
// - Combine selector resets to code 1, the maximum function.
// - Code 0 delivers the lower of the two feedbacks.
// - Code 1 delivers the higher of the two feedbacks.
// - Code 2 delivers the sum; reference is remote plus setpoint one.
// - Code 3 delivers feedback two minus feedback one.
// - Code 4 delivers the mean; reference is remote plus setpoint one.
// - Code 5 picks the signed larger zone error and its setpoint.
// - Code 6 picks the signed smaller zone error and its setpoint.
// - Zone errors compare signed, so any positive beats any negative.
// - Code 7 uses feedback one only, against setpoint one.
// - Code 8 uses feedback two only, against setpoint two.
// - Single setpoint: remote plus setpoint one is compared to the feedback.
// - Setpoints are limited to the reference range and reset to zero.
// - Setpoint two is used only in closed loop, with code 5, 6 or 8.
// - Feedback logic runs in open and closed loop; open loop only displays.
`ifndef DFC_DEFS_SVH
`define DFC_DEFS_SVH

// Register byte addresses
`define DFC_ADDR_CTRL    8'h00
`define DFC_ADDR_COMBINE 8'h04
`define DFC_ADDR_BUS_FB1 8'h08
`define DFC_ADDR_BUS_FB2 8'h0C
`define DFC_ADDR_SP1     8'h10
`define DFC_ADDR_SP2     8'h14
`define DFC_ADDR_REF_MIN 8'h18
`define DFC_ADDR_REF_MAX 8'h1C
`define DFC_ADDR_FB_OUT  8'h20
`define DFC_ADDR_REF_OUT 8'h24
`define DFC_ADDR_ERR_OUT 8'h28
`define DFC_ADDR_ZONE    8'h2C

// Control field positions
`define DFC_CTRL_SHAPE_BIT  0
`define DFC_CTRL_CLOSED_BIT 1

// Combine codes
`define DFC_CMB_MIN     4'h0
`define DFC_CMB_MAX     4'h1
`define DFC_CMB_SUM     4'h2
`define DFC_CMB_DIFF    4'h3
`define DFC_CMB_AVG     4'h4
`define DFC_CMB_ZMAXERR 4'h5
`define DFC_CMB_ZMINERR 4'h6
`define DFC_CMB_FB1     4'h7
`define DFC_CMB_FB2     4'h8

// Reset values
`define DFC_RST_COMBINE 4'h1
`define DFC_RST_SP      16'h0000
`define DFC_RST_REF_MIN 16'h8000
`define DFC_RST_REF_MAX 16'h7FFF

`endif

// File: logic/dfc_pkg.sv
// Types shared by the dual feedback setpoint combiner
`include "dfc_defs.svh"
package dfc_pkg;
  typedef enum logic [3:0] {
    CMB_MIN     = `DFC_CMB_MIN,
    CMB_MAX     = `DFC_CMB_MAX,
    CMB_SUM     = `DFC_CMB_SUM,
    CMB_DIFF    = `DFC_CMB_DIFF,
    CMB_AVG     = `DFC_CMB_AVG,
    CMB_ZMAXERR = `DFC_CMB_ZMAXERR,
    CMB_ZMINERR = `DFC_CMB_ZMINERR,
    CMB_FB1     = `DFC_CMB_FB1,
    CMB_FB2     = `DFC_CMB_FB2
  } combine_t;
endpackage

// File: tb/process_transmitters.sv
// Model of the process transmitters that feed the voltage inputs
`timescale 1ns/1ps
module process_transmitters (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic signed [15:0] t1_set,
  input  wire logic signed [15:0] t2_set,
  input  wire logic signed [15:0] ref_set,
  output logic signed [15:0]      term1_value,
  output logic signed [15:0]      term2_value,
  output logic signed [15:0]      remote_ref
);
  // both voltage inputs
  // Transmitter outputs settle one cycle after the bench sets them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      term1_value <= 16'sh0000;
      term2_value <= 16'sh0000;
      remote_ref  <= 16'sh0000;
    end
    else
    begin
      term1_value <= t1_set;
      term2_value <= t2_set;
      remote_ref  <= ref_set;
    end
  end
endmodule

// File: tb/dual_feedback_setpoint_combiner_bench.sv
// Self-checking bench for the dual feedback setpoint combiner
`timescale 1ns/1ps
module dual_feedback_setpoint_combiner_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, zone2_active, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [15:0] t1_set, t2_set, ref_set, term1_value, term2_value, remote_ref;
  logic signed [19:0] feedback_out, reference_out, error_out;
  int n_mismatch;
  int checks_done;
  int ef[9] = '{150, 170, 320, 20, 160, 150, 170, 150, 170};
  int er_exp[9] = '{310, 310, 310, 310, 310, 310, -190, 310, -190};
  logic ez[9] = '{0, 0, 0, 0, 0, 0, 1, 0, 1};

  // Clock of 4 ns period
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  process_transmitters u_process_transmitters (.pclk(pclk), .presetn(presetn),
    .t1_set(t1_set), .t2_set(t2_set), .ref_set(ref_set), .term1_value(term1_value),
    .term2_value(term2_value), .remote_ref(remote_ref));

  dual_feedback_setpoint_combiner u_dual_feedback_setpoint_combiner (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term1_value(term1_value), .term2_value(term2_value), .remote_ref(remote_ref),
    .feedback_out(feedback_out), .reference_out(reference_out), .error_out(error_out),
    .zone2_active(zone2_active));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, 32'h0);
  endtask

  // Compares the datapath outputs once the two-stage pipe has settled
  task automatic chkout(input int f, input int r, input logic z);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk(32'(feedback_out), 32'(f));
    chk(32'(reference_out), 32'(r));
    chk(32'(error_out), 32'(r - f));
    chk({31'h0, zone2_active}, {31'h0, z});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    rdchk(8'h04, 32'h1);
    rdchk(8'h10, 32'h0);
    rdchk(8'h14, 32'h0);
    $display("reset values done");
  endtask

  task automatic test_codes();
    wr(8'h08, 32'h64);
    wr(8'h0C, 32'hC8);
    wr(8'h10, 32'h12C);
    wr(8'h14, 32'hFFFFFF38);
    wr(8'h00, 32'h2);
    t1_set <= 16'sh0032;
    t2_set <= -16'sh001E;
    ref_set <= 16'sh000A;
    for (int i = 0; i < 9; i++)
    begin
      wr(8'h04, 32'(i));
      chkout(ef[i], er_exp[i], ez[i]);
    end
    $display("combine codes done");
  endtask

  task automatic test_open();
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    chkout(150, 10, 1'b0);
    wr(8'h04, 32'h8);
    chkout(170, 10, 1'b0);
    $display("open loop done");
  endtask

  task automatic test_shape_clamp();
    wr(8'h04, 32'h7);
    wr(8'h00, 32'h3);
    chkout(12, 310, 1'b0);
    wr(8'h00, 32'h2);
    wr(8'h1C, 32'h64);
    wr(8'h10, 32'h7FFF);
    chkout(150, 110, 1'b0);
    rdchk(8'h10, 32'h7FFF);
    $display("shaping and clamp done");
  endtask

  task automatic test_refuse();
    wr(8'h04, 32'h9);
    rdchk(8'h04, 32'h7);
    apb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("refusals done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    t1_set = 16'sh0000;
    t2_set = 16'sh0000;
    ref_set = 16'sh0000;
    n_mismatch = 0;
    checks_done = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_codes();
    test_open();
    test_shape_clamp();
    test_refuse();
    tally_and_finish();
  end
endmodule
